// *** hdl/mst_defs.vh ***
// Register offsets, command fields and table layout for the MIB/static block
`ifndef MST_DEFS_VH
`define MST_DEFS_VH
// Host register byte offsets
`define MST_OFF_CMD 11'h0C8
`define MST_OFF_DLO 11'h02C
`define MST_OFF_DHI 11'h02E
`define MST_OFF_D2 11'h028
`define MST_OFF_D3 11'h02A
// Command word fields
`define MST_CMD_RD_BIT 12
`define MST_CMD_TBL_HI 11
`define MST_CMD_TBL_LO 10
`define MST_CMD_OFF_HI 9
`define MST_TBL_STATIC 2'h0
`define MST_TBL_MIB 2'h3
`define MST_CMD_RST 16'h0000
// Indirect offsets inside the counter space
`define MST_PORT1_BASE 7'h00
`define MST_PORT2_BASE 7'h20
`define MST_PORT3_BASE 7'h40
`define MST_MIB_LO_OFF 5'h10
`define MST_DROP_BASE 10'h100
`define MST_DROP_LAST 10'h105
// Per-port counter word
`define MST_CNT_OVF_BIT 31
`define MST_CNT_VLD_BIT 30
`define MST_CNT_W 30
`define MST_DROP_W 16
// Frame length bins and late collision threshold
`define MST_LEN_128 12'h080
`define MST_LEN_256 12'h100
`define MST_LEN_512 12'h200
`define MST_LEN_1024 12'h400
`define MST_LEN_MAX 12'h7D0
`define MST_LATE_BITS 12'h200
// Static entry layout
`define MST_ENT_W 58
`define MST_FID_HI 57
`define MST_FID_LO 54
`define MST_USEFID_BIT 53
`define MST_OVR_BIT 52
`define MST_VLD_BIT 51
`define MST_FWD_HI 50
`define MST_FWD_LO 48
`define MST_FWD_ALL 3'h7
`define MST_STATIC_DEPTH 8
`endif

// *** hdl/mst_mib_cnt.v ***
// Saturation-free counter with read-clear and sticky overflow
`timescale 1ns/100ps
module mst_mib_cnt #(
  parameter CW = 30,
  parameter IW = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire [IW-1:0] inc_i,
  input wire clr_i,
  // State
  output wire [CW-1:0] cnt_o,
  output wire ovf_o
);
  reg [CW-1:0] cnt_r;
  reg ovf_r;
  wire [CW-1:0] base_w;
  wire [CW:0] sum_w;

  // An event in the clearing cycle is added to zero, so it is not lost
  assign base_w = clr_i ? {CW{1'b0}} : cnt_r;
  assign sum_w = {1'b0, base_w} + {{(CW+1-IW){1'b0}}, inc_i};

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= {CW{1'b0}};
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= sum_w[CW-1:0];
      ovf_r <= sum_w[CW] | (ovf_r & ~clr_i);
    end
  end

  assign cnt_o = cnt_r;
  assign ovf_o = ovf_r;
endmodule // mst_mib_cnt

// *** hdl/mst_mib_static.v ***
// MIB counters with indirect host access and the static MAC table
//
// Notes on behaviour
// R1: count received frames in four length bins
// R2: sum good tx octets per priority, pause included
// R3: count collisions later than 512 bit-times
// R4: count pause, broadcast, multicast, unicast tx frames
// R5: count deferrals, collisions, excess, single, multiple
// R6: dropped counters are 16 bits, no flags
// R7: dropped counters at offsets 0x100 to 0x105
// R8: command word at 0xC8 starts a counter read
// R9: host reads high word first, retries on invalid
// R10: port base plus offset selects the counter
// R11: host reads only low word for dropped counters
// R12: reading a per-port counter clears it
// R13: dropped counters survive reads unchanged
// R14: destination lookups use static table, source ones not
// R15: static hit beats dynamic hit
// R16: static entries never age out
// R17: entry bits 57-54 hold filter identifier
// R18: bit 53 adds filter identifier to match
// R19: override bit ignores port disables and valid
// R20: entry used only when valid or overridden
// R21: bits 50-48 port mask, all means others
// R22: eight entries, MAC address in 47-0
// R23: counter word holds overflow, valid, 30-bit count
// R24: port ranges start at 0x00, 0x20, 0x40
// R25: low data word 15-0, high 31-16
// R26: host loads data words before a write command
// R27: read data ready next cycle, held until next command
`timescale 1ns/100ps
`include "mst_defs.vh"
module mst_mib_static #(
  parameter NP = 3,
  parameter OW = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Host register port, 16-bit words
  input wire [10:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // Receive frame events, one lane per port
  input wire [NP-1:0] rx_frame_i,
  input wire [NP*12-1:0] rx_len_i,
  // Transmit frame completion events
  input wire [NP-1:0] tx_frame_i,
  input wire [NP-1:0] tx_good_i,
  input wire [NP-1:0] tx_pause_i,
  input wire [NP-1:0] tx_bcast_i,
  input wire [NP-1:0] tx_mcast_i,
  input wire [NP-1:0] tx_hiprio_i,
  input wire [NP*OW-1:0] tx_octets_i,
  input wire [NP-1:0] tx_deferred_i,
  input wire [NP-1:0] tx_excess_i,
  input wire [NP*5-1:0] tx_colls_i,
  // Single collision events
  input wire [NP-1:0] tx_coll_i,
  input wire [NP*12-1:0] tx_coll_bit_i,
  input wire [NP-1:0] half_duplex_i,
  // Resource drop events
  input wire [NP-1:0] tx_drop_i,
  input wire [NP-1:0] rx_drop_i,
  // Address lookup request
  input wire lkp_req_i,
  input wire lkp_is_sa_i,
  input wire [47:0] lkp_addr_i,
  input wire [3:0] lkp_fid_i,
  input wire [1:0] lkp_ingress_i,
  input wire dyn_hit_i,
  input wire [2:0] dyn_ports_i,
  input wire [2:0] port_txen_i,
  input wire [2:0] port_rxen_i,
  // Lookup result
  output reg lkp_vld_o,
  output reg lkp_hit_o,
  output reg lkp_static_o,
  output reg [2:0] lkp_ports_o
);
  localparam NC = NP * 16;
  localparam ND = NP * 2;

  function in_bin;
    input [11:0] len;
    input [11:0] lo;
    input [11:0] hi;
    begin
      in_bin = (len >= lo) && (len < hi);
    end
  endfunction

  function [OW-1:0] ev;
    input b;
    begin
      ev = {{(OW-1){1'b0}}, b};
    end
  endfunction

  // Host-visible registers
  reg [15:0] cmd_r;
  reg cmd_go_r;
  reg [15:0] dlo_r;
  reg [15:0] dhi_r;
  reg [15:0] d2_r;
  reg [9:0] d3_r;
  reg cnt_vld_r;
  reg [`MST_ENT_W-1:0] stab_r [0:`MST_STATIC_DEPTH-1];
  reg [15:0] rdata_nxt;
  reg [2:0] ports_nxt;
  reg hit_nxt;
  reg stat_nxt;

  wire [NC*OW-1:0] inc_w;
  wire [NC-1:0] clr_w;
  wire [`MST_CNT_W-1:0] pcnt_w [0:NC-1];
  wire [NC-1:0] povf_w;
  wire [`MST_DROP_W-1:0] dcnt_w [0:ND-1];
  wire [ND-1:0] dinc_w;

  wire cmd_wr_w;
  wire [9:0] ioff_w;
  wire [1:0] itbl_w;
  wire ird_w;
  wire [1:0] iport_w;
  wire pcnt_sel_w;
  wire drop_sel_w;
  wire [5:0] pidx_w;
  wire [2:0] didx_w;
  wire [2:0] sidx_w;
  wire [`MST_ENT_W-1:0] sent_w;

  assign cmd_wr_w = reg_wr_i && (reg_addr_i == `MST_OFF_CMD);
  assign ioff_w = cmd_r[`MST_CMD_OFF_HI:0];
  assign itbl_w = cmd_r[`MST_CMD_TBL_HI:`MST_CMD_TBL_LO];
  assign ird_w = cmd_r[`MST_CMD_RD_BIT];
  assign iport_w = ioff_w[6:5];
  // Base 0x00/0x20/0x40 lands in bits 6:5, only the upper half is built
  assign pcnt_sel_w = (ioff_w[9:7] == 3'h0) && (iport_w < NP) &&
                      ioff_w[4]; // R24 R10
  assign drop_sel_w = (ioff_w >= `MST_DROP_BASE) &&
                      (ioff_w <= `MST_DROP_LAST); // R7
  assign pidx_w = {iport_w, ioff_w[3:0]};
  assign didx_w = ioff_w[2:0];
  assign sidx_w = ioff_w[2:0];
  assign sent_w = stab_r[sidx_w];

  // Event decode into per-counter increments
  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      wire [11:0] len = rx_len_i[p*12 +: 12];
      wire [4:0] colls = tx_colls_i[p*5 +: 5];
      wire good = tx_frame_i[p] & tx_good_i[p];
      wire [OW-1:0] oct = tx_octets_i[p*OW +: OW];
      wire rx = rx_frame_i[p];
      wire late = tx_coll_bit_i[p*12 +: 12] > `MST_LATE_BITS;
      wire bc = tx_bcast_i[p];
      wire mc = tx_mcast_i[p] & ~bc;
      wire hi = tx_hiprio_i[p];
      wire [16*OW-1:0] v;
      assign v[0*OW +: OW] = ev(rx & in_bin(len, `MST_LEN_128,
                                `MST_LEN_256)); // R1
      assign v[1*OW +: OW] = ev(rx & in_bin(len, `MST_LEN_256,
                                `MST_LEN_512)); // R1
      assign v[2*OW +: OW] = ev(rx & in_bin(len, `MST_LEN_512,
                                `MST_LEN_1024)); // R1
      assign v[3*OW +: OW] = ev(rx & (len >= `MST_LEN_1024) &
                                (len <= `MST_LEN_MAX)); // R1
      // Pause frames arrive as good frames and add to either total
      assign v[4*OW +: OW] = (good & ~hi) ? oct : {OW{1'b0}}; // R2
      assign v[5*OW +: OW] = (good & hi) ? oct : {OW{1'b0}}; // R2
      assign v[6*OW +: OW] = ev(tx_coll_i[p] & late); // R3
      assign v[7*OW +: OW] = ev(tx_frame_i[p] & tx_pause_i[p]); // R4
      assign v[8*OW +: OW] = ev(good & bc); // R4
      assign v[9*OW +: OW] = ev(good & mc); // R4
      assign v[10*OW +: OW] = ev(good & ~bc & ~tx_mcast_i[p] &
                                 ~tx_pause_i[p]); // R4
      assign v[11*OW +: OW] = ev(tx_frame_i[p] & tx_deferred_i[p]); // R5
      assign v[12*OW +: OW] = ev(tx_coll_i[p] & half_duplex_i[p]); // R5
      assign v[13*OW +: OW] = ev(tx_frame_i[p] & tx_excess_i[p]); // R5
      assign v[14*OW +: OW] = ev(good & (colls == 5'h01)); // R5
      assign v[15*OW +: OW] = ev(good & (colls > 5'h01)); // R5
      assign inc_w[p*16*OW +: 16*OW] = v;
      assign dinc_w[p] = tx_drop_i[p];
      assign dinc_w[NP+p] = rx_drop_i[p];
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < NC; c = c + 1) begin : g_pcnt
      // Read-clear fires in the cycle the selected value is captured
      assign clr_w[c] = cmd_go_r && ird_w && (itbl_w == `MST_TBL_MIB) &&
                        pcnt_sel_w && (pidx_w == c); // R12
      mst_mib_cnt #(
        .CW(`MST_CNT_W),
        .IW(OW)
      ) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(inc_w[c*OW +: OW]),
        .clr_i(clr_w[c]),
        .cnt_o(pcnt_w[c]),
        .ovf_o(povf_w[c])
      );
    end
    for (c = 0; c < ND; c = c + 1) begin : g_dcnt
      // Never cleared, wraps silently; software tracks overflow
      mst_mib_cnt #(
        .CW(`MST_DROP_W),
        .IW(1)
      ) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(dinc_w[c]),
        .clr_i(1'b0),
        .cnt_o(dcnt_w[c]),
        .ovf_o()
      ); // R13 R6
    end
  endgenerate

  // Command and data registers
  integer i;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= `MST_CMD_RST;
      cmd_go_r <= 1'b0;
      dlo_r <= 16'h0000;
      dhi_r <= 16'h0000;
      d2_r <= 16'h0000;
      d3_r <= 10'h000;
      cnt_vld_r <= 1'b0;
      for (i = 0; i < `MST_STATIC_DEPTH; i = i + 1) begin
        stab_r[i] <= {`MST_ENT_W{1'b0}};
      end
    end else begin
      cnt_vld_r <= 1'b1;
      cmd_go_r <= cmd_wr_w; // R8
      if (cmd_wr_w) begin
        cmd_r <= reg_wdata_i; // R8
      end
      if (reg_wr_i && (reg_addr_i == `MST_OFF_DLO)) begin
        dlo_r <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `MST_OFF_DHI)) begin
        dhi_r <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `MST_OFF_D2)) begin
        d2_r <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `MST_OFF_D3)) begin
        d3_r <= reg_wdata_i[9:0];
      end
      // Data lands one cycle after the command write and then holds
      if (cmd_go_r && ird_w && (itbl_w == `MST_TBL_MIB)) begin // R27
        if (drop_sel_w) begin
          dhi_r <= 16'h0000; // R6
          dlo_r <= dcnt_w[didx_w]; // R11
        end else if (pcnt_sel_w) begin
          dhi_r <= {povf_w[pidx_w], cnt_vld_r,
                    pcnt_w[pidx_w][29:16]}; // R23 R25
          dlo_r <= pcnt_w[pidx_w][15:0]; // R25
        end else begin
          // Unbuilt offsets read as a valid zero so polling ends
          dhi_r <= {1'b0, cnt_vld_r, 14'h0000}; // R9
          dlo_r <= 16'h0000;
        end
      end
      if (cmd_go_r && (itbl_w == `MST_TBL_STATIC)) begin
        if (ird_w) begin
          d3_r <= sent_w[57:48];
          d2_r <= sent_w[47:32];
          dhi_r <= sent_w[31:16];
          dlo_r <= sent_w[15:0];
        end else begin
          // Only the host loads entries; no aging path exists
          stab_r[sidx_w] <= {d3_r, d2_r, dhi_r, dlo_r}; // R26 R22 R16
        end
      end
    end
  end

  // Read mux, registered for one cycle of latency
  always @* begin
    case (reg_addr_i)
      `MST_OFF_CMD: rdata_nxt = cmd_r;
      `MST_OFF_DLO: rdata_nxt = dlo_r;
      `MST_OFF_DHI: rdata_nxt = dhi_r;
      `MST_OFF_D2: rdata_nxt = d2_r;
      `MST_OFF_D3: rdata_nxt = {6'h00, d3_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Static lookup; lowest matching index wins
  reg found;
  reg [`MST_ENT_W-1:0] ent;
  reg [`MST_ENT_W-1:0] win;
  reg usable;
  reg mt;
  reg [2:0] ing_mask;
  reg [2:0] mask;
  integer k;
  always @* begin
    found = 1'b0;
    win = {`MST_ENT_W{1'b0}};
    ent = {`MST_ENT_W{1'b0}};
    usable = 1'b0;
    mt = 1'b0;
    for (k = 0; k < `MST_STATIC_DEPTH; k = k + 1) begin
      ent = stab_r[k];
      usable = ent[`MST_VLD_BIT] | ent[`MST_OVR_BIT]; // R20 R19
      mt = (ent[47:0] == lkp_addr_i) &&
           (!ent[`MST_USEFID_BIT] ||
            (ent[`MST_FID_HI:`MST_FID_LO] == lkp_fid_i)); // R18 R17 R22
      if (!found && usable && mt) begin
        found = 1'b1;
        win = ent;
      end
    end
    case (lkp_ingress_i)
      2'h0: ing_mask = 3'h1;
      2'h1: ing_mask = 3'h2;
      2'h2: ing_mask = 3'h4;
      default: ing_mask = 3'h0;
    endcase
    mask = win[`MST_FWD_HI:`MST_FWD_LO];
    if (mask == `MST_FWD_ALL) begin
      mask = ~ing_mask; // R21
    end
    if (!win[`MST_OVR_BIT]) begin
      // Port disables apply unless the entry overrides them
      mask = mask & port_txen_i;
      if ((port_rxen_i & ing_mask) == 3'h0) begin
        mask = 3'h0;
      end
    end // R19
    // Source lookups skip the static table entirely
    stat_nxt = found && !lkp_is_sa_i; // R14
    if (stat_nxt) begin
      ports_nxt = mask; // R15 R21
      hit_nxt = 1'b1;
    end else begin
      ports_nxt = dyn_hit_i ? dyn_ports_i : 3'h0;
      hit_nxt = dyn_hit_i;
    end
  end

  // Registered outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      lkp_vld_o <= 1'b0;
      lkp_hit_o <= 1'b0;
      lkp_static_o <= 1'b0;
      lkp_ports_o <= 3'h0;
    end else begin
      reg_rdata_o <= rdata_nxt;
      lkp_vld_o <= lkp_req_i;
      if (lkp_req_i) begin
        lkp_hit_o <= hit_nxt;
        lkp_static_o <= stat_nxt;
        lkp_ports_o <= ports_nxt;
      end
    end
  end
endmodule // mst_mib_static

// *** sim/mst_mib_static_checker.sv ***
// Checker on the register port and lookup result of the MIB/static block
`timescale 1ns/100ps
`include "mst_defs.vh"
module mst_mib_static_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [10:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  // Lookup request and result
  input wire lkp_req_i,
  input wire lkp_is_sa_i,
  input wire dyn_hit_i,
  input wire [2:0] dyn_ports_i,
  input wire lkp_vld_o,
  input wire lkp_hit_o,
  input wire lkp_static_o,
  input wire [2:0] lkp_ports_o
);
  wire mapped = reg_addr_i == `MST_OFF_CMD || reg_addr_i == `MST_OFF_DLO ||
    reg_addr_i == `MST_OFF_DHI || reg_addr_i == `MST_OFF_D2 ||
    reg_addr_i == `MST_OFF_D3;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  vld_after_req_a: assert property (lkp_req_i |=> lkp_vld_o)
    else $error("lookup answer missing");
  vld_no_req_a: assert property (!lkp_req_i |=> !lkp_vld_o)
    else $error("lookup answer without request");
  sa_not_static_a: assert property (
    lkp_req_i && lkp_is_sa_i |=> !lkp_static_o)
    else $error("source lookup used static table");
  sa_dyn_used_a: assert property (
    lkp_req_i && lkp_is_sa_i && dyn_hit_i |=>
    lkp_hit_o && lkp_ports_o == $past(dyn_ports_i))
    else $error("source lookup lost dynamic result");
  static_hit_a: assert property (lkp_vld_o && lkp_static_o |-> lkp_hit_o)
    else $error("static result without hit");
  result_hold_a: assert property (
    !lkp_vld_o |-> $stable({lkp_hit_o, lkp_static_o, lkp_ports_o}))
    else $error("lookup result moved without answer");
  unmapped_zero_a: assert property (!mapped |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  cmd_readback_a: assert property (
    reg_wr_i && reg_addr_i == `MST_OFF_CMD ##1
    !reg_wr_i && reg_addr_i == `MST_OFF_CMD |=>
    reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("command word read back wrong");
  cover property (lkp_vld_o && lkp_static_o);
  cover property (lkp_vld_o && !lkp_static_o && lkp_hit_o);
  cover property (reg_wr_i && reg_addr_i == `MST_OFF_CMD);
endmodule // mst_mib_static_checker
bind mst_mib_static mst_mib_static_checker u_mst_mib_static_checker (
  .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
  .lkp_req_i, .lkp_is_sa_i, .dyn_hit_i, .dyn_ports_i, .lkp_vld_o,
  .lkp_hit_o, .lkp_static_o, .lkp_ports_o);

// *** sim/mst_host_model.sv ***
// Host processor model driving the indirect register port
`timescale 1ns/100ps
`include "mst_defs.vh"
module mst_host_model (
  // Clock
  input wire clk_i,
  // Register port toward the block
  output reg [10:0] reg_addr_o = 11'h7FE,
  output reg reg_wr_o = 1'b0,
  output reg [15:0] reg_wdata_o = 16'h0000,
  input wire [15:0] reg_rdata_i
);
  task wr(input [10:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wr_o <= 1'b1;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      // Stale data must not pass for a second write
      reg_wdata_o <= ~d;
    end
  endtask
  task rd(input [10:0] a, output [15:0] d);
    begin
      @(posedge clk_i);
      reg_addr_o <= a;
      @(posedge clk_i);
      #1 d = reg_rdata_i;
    end
  endtask
  // Retries are bounded so a stuck valid flag cannot hang the host
  task mib(input [9:0] off, output [31:0] v);
    integer i;
    begin
      wr(`MST_OFF_CMD, {6'h07, off});
      v = 32'h0;
      for (i = 0; i < 4 && !v[30]; i = i + 1)
        rd(`MST_OFF_DHI, v[31:16]);
      rd(`MST_OFF_DLO, v[15:0]);
    end
  endtask
  task ent(input [2:0] idx, input [57:0] e);
    begin
      wr(`MST_OFF_D3, {6'h00, e[57:48]});
      wr(`MST_OFF_D2, e[47:32]);
      wr(`MST_OFF_DHI, e[31:16]);
      wr(`MST_OFF_DLO, e[15:0]);
      wr(`MST_OFF_CMD, {13'h0000, idx});
    end
  endtask
endmodule // mst_host_model

// *** sim/test_mst_mib_static.sv ***
// Self-checking bench for the MIB counters and static MAC table
`timescale 1ns/100ps
`include "mst_defs.vh"
module test_mst_mib_static;
  reg clk_i, rst_i, lkp_req_i, lkp_is_sa_i, dyn_hit_i;
  reg [2:0] rx_frame_i, tx_frame_i, tx_good_i, tx_pause_i, tx_bcast_i;
  reg [2:0] tx_mcast_i, tx_hiprio_i, tx_deferred_i, tx_excess_i, tx_coll_i;
  reg [2:0] half_duplex_i, tx_drop_i, rx_drop_i, dyn_ports_i, port_txen_i;
  reg [2:0] port_rxen_i;
  reg [35:0] rx_len_i, tx_coll_bit_i;
  reg [32:0] tx_octets_i;
  reg [14:0] tx_colls_i;
  reg [47:0] lkp_addr_i;
  reg [3:0] lkp_fid_i;
  reg [1:0] lkp_ingress_i;
  wire [10:0] reg_addr_i;
  wire [15:0] reg_wdata_i, reg_rdata_o;
  wire reg_wr_i, lkp_vld_o, lkp_hit_o, lkp_static_o;
  wire [2:0] lkp_ports_o;
  integer n_errors, comparisons;
  reg [31:0] v;
  mst_mib_static u_mst_mib_static (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o, .rx_frame_i, .rx_len_i, .tx_frame_i,
    .tx_good_i, .tx_pause_i, .tx_bcast_i, .tx_mcast_i, .tx_hiprio_i,
    .tx_octets_i, .tx_deferred_i, .tx_excess_i, .tx_colls_i, .tx_coll_i,
    .tx_coll_bit_i, .half_duplex_i, .tx_drop_i, .rx_drop_i, .lkp_req_i,
    .lkp_is_sa_i, .lkp_addr_i, .lkp_fid_i, .lkp_ingress_i, .dyn_hit_i,
    .dyn_ports_i, .port_txen_i, .port_rxen_i, .lkp_vld_o, .lkp_hit_o,
    .lkp_static_o, .lkp_ports_o);
  mst_host_model u_mst_host_model (.clk_i, .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task results;
    begin
      $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Dropped counters answer in the low word only
  task mchk(input [9:0] off, input [31:0] exp);
    begin
      v = 32'h0;
      if (off < 10'h100)
        u_mst_host_model.mib(off, v);
      else begin
        u_mst_host_model.wr(`MST_OFF_CMD, {6'h07, off});
        u_mst_host_model.rd(`MST_OFF_DLO, v[15:0]);
      end
      chk("counter", exp, v);
    end
  endtask
  task clr;
    begin
      @(posedge clk_i);
      rx_frame_i <= 3'h0;
      tx_frame_i <= 3'h0;
      tx_coll_i <= 3'h0;
      tx_drop_i <= 3'h0;
    end
  endtask
  task lk(input [47:0] a, input sa, input [1:0] ing, input [2:0] txen,
    input [3:0] dyn, input [4:0] exp);
    begin
      @(posedge clk_i);
      lkp_req_i <= 1'b1;
      lkp_addr_i <= a;
      lkp_is_sa_i <= sa;
      lkp_ingress_i <= ing;
      port_txen_i <= txen;
      {dyn_hit_i, dyn_ports_i} <= dyn;
      @(posedge clk_i);
      lkp_req_i <= 1'b0;
      #1 chk("lookup", {27'h0, exp},
        {27'h0, lkp_hit_o, lkp_static_o, lkp_ports_o});
    end
  endtask
  task t_mib;
    begin
      @(posedge clk_i);
      rx_frame_i <= 3'h7;
      rx_len_i <= {12'h7D0, 12'h080, 12'h3FF};
      clr;
      mchk(10'h030, 32'h40000001);
      mchk(10'h012, 32'h40000001);
      mchk(10'h030, 32'h40000000);
      mchk(10'h053, 32'h40000001);
    end
  endtask
  task t_tx;
    begin
      @(posedge clk_i);
      tx_frame_i <= 3'h7;
      tx_good_i <= 3'h3;
      tx_pause_i <= 3'h2;
      tx_bcast_i <= 3'h1;
      tx_hiprio_i <= 3'h1;
      tx_deferred_i <= 3'h1;
      tx_excess_i <= 3'h4;
      tx_octets_i <= {11'h000, 11'h040, 11'h064};
      tx_colls_i <= {10'h0, 5'h01};
      tx_coll_i <= 3'h1;
      tx_coll_bit_i <= {24'h0, 12'h201};
      half_duplex_i <= 3'h1;
      @(posedge clk_i);
      tx_frame_i <= 3'h0;
      tx_coll_bit_i <= {24'h0, 12'h200};
      clr;
      mchk(10'h015, 32'h40000064);
      mchk(10'h014, 32'h40000000);
      mchk(10'h018, 32'h40000001);
      mchk(10'h01B, 32'h40000001);
      mchk(10'h01E, 32'h40000001);
      mchk(10'h016, 32'h40000001);
      mchk(10'h01C, 32'h40000002);
      mchk(10'h034, 32'h40000040);
      mchk(10'h037, 32'h40000001);
      mchk(10'h03A, 32'h40000000);
      mchk(10'h05D, 32'h40000001);
    end
  endtask
  task t_drop;
    begin
      @(posedge clk_i);
      tx_drop_i <= 3'h4;
      rx_drop_i <= 3'h1;
      @(posedge clk_i);
      rx_drop_i <= 3'h0;
      clr;
      mchk(10'h102, 32'h2);
      mchk(10'h102, 32'h2);
      mchk(10'h103, 32'h1);
      u_mst_host_model.rd(`MST_OFF_DHI, v[15:0]);
      chk("drop high word", 32'h0, {16'h0, v[15:0]});
      u_mst_host_model.rd(11'h030, v[15:0]);
      chk("unmapped", 32'h0, {16'h0, v[15:0]});
    end
  endtask
  task t_static;
    begin
      u_mst_host_model.ent(3'h0, {7'h5D, 3'h1, 48'hF00000000A01});
      u_mst_host_model.ent(3'h2, {7'h1D, 3'h7, 48'hF00000000A01});
      u_mst_host_model.ent(3'h5, {7'h00, 3'h4, 48'h00000000B002});
      u_mst_host_model.ent(3'h7, {7'h02, 3'h4, 48'h00000000C003});
      u_mst_host_model.wr(`MST_OFF_CMD, 16'h1002);
      u_mst_host_model.rd(`MST_OFF_D3, v[31:16]);
      u_mst_host_model.rd(`MST_OFF_D2, v[15:0]);
      chk("entry upper", 32'h00EFF000, v);
      u_mst_host_model.rd(`MST_OFF_DHI, v[31:16]);
      u_mst_host_model.rd(`MST_OFF_DLO, v[15:0]);
      chk("entry lower", 32'h00000A01, v);
      lk(48'hF00000000A01, 1'b0, 2'h0, 3'h7, 4'hC, 5'h1E);
      lk(48'hF00000000A01, 1'b1, 2'h0, 3'h7, 4'hA, 5'h12);
      lk(48'h00000000B002, 1'b0, 2'h2, 3'h7, 4'h0, 5'h00);
      lk(48'h00000000C003, 1'b0, 2'h1, 3'h0, 4'hA, 5'h1C);
      @(posedge clk_i);
      port_rxen_i <= 3'h6;
      lk(48'hF00000000A01, 1'b0, 2'h0, 3'h7, 4'hC, 5'h18);
      lk(48'h00000000C003, 1'b0, 2'h0, 3'h7, 4'h0, 5'h1C);
      port_rxen_i <= 3'h7;
    end
  endtask
  initial begin
    {lkp_req_i, lkp_is_sa_i, rx_frame_i, tx_frame_i, tx_good_i, tx_pause_i,
      tx_bcast_i, tx_mcast_i, tx_hiprio_i, tx_deferred_i, tx_excess_i,
      tx_coll_i, half_duplex_i, tx_drop_i, rx_drop_i, rx_len_i, tx_octets_i,
      tx_coll_bit_i, tx_colls_i, lkp_addr_i, lkp_ingress_i, dyn_hit_i,
      dyn_ports_i} = 0;
    port_txen_i = 3'h7;
    port_rxen_i = 3'h7;
    lkp_fid_i = 4'h3;
    n_errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_mib;
    t_tx;
    t_drop;
    t_static;
    results;
  end
  initial begin
    #500000;
    n_errors = n_errors + 1;
    results;
  end
endmodule // test_mst_mib_static
